// file: core/pies_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pies_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clocking
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             clkEn,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];          // storage
	logic [AW-1:0]    wrPtr, next_wrPtr;    // write pointer
	logic [AW-1:0]    rdPtr, next_rdPtr;    // read pointer
	logic [AW:0]      count, next_count;    // fill level
	logic [WIDTH-1:0] next_outData;         // registered head
	logic             push, pop;

	// handshakes are combinational from the fill level
	assign inReady  = (count < (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// next pointers and level
	always_comb begin
		next_wrPtr = push ? AW'(wrPtr + 1'b1) : wrPtr;
		next_rdPtr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_outData = mem[next_rdPtr];
		if (push && (wrPtr == next_rdPtr)) begin
			next_outData = inData; // write into the slot that becomes head
		end
	end

	// registers; head data registered so output comes from a flop
	always_ff @(posedge mclk) begin
		if (reset) begin
			wrPtr   <= '0;
			rdPtr   <= '0;
			count   <= '0;
			outData <= '0;
		end else if (clkEn) begin
			wrPtr   <= next_wrPtr;
			rdPtr   <= next_rdPtr;
			count   <= next_count;
			outData <= next_outData;
			if (push) begin
				mem[wrPtr] <= inData;
			end
		end
	end
endmodule
`default_nettype wire

// file: core/pies_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module pies_scheduler
	import pies_pkg::*;
#(
	// clock cycles in one interval tick; a bench may shorten it to fit whole intervals
	parameter int TICK_LEN = TICK_CYCLES
) (
	// clocking
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  clkEn,
	// static configuration straps
	input  wire logic                  isOutput,
	input  wire logic                  hasOutputImage,
	input  wire logic                  localChassis,
	input  wire logic [15:0]           deviceIdent,
	// connection requests
	input  wire logic                  reqValid,
	input  wire pies_conn_req_t        req,
	output logic                       reqAccept,
	output logic                       reqReject,
	// output data from the owner
	input  wire logic                  outDataValid,
	input  wire logic [CHAN_W-1:0]     outDataChan,
	// channel sampling / terminal readback
	output logic                       sampleReq,
	output logic [CHAN_W-1:0]          sampleChan,
	input  wire logic [DATA_W-1:0]     sampleValue,
	// produced stream
	output logic                       prodValid,
	input  wire logic                  prodReady,
	output pies_word_t                 prodData,
	// status
	output logic                       running,
	output logic [NCONN-1:0]           ownerMask,
	output logic [NCONN-1:0]           listenMask,
	output logic [PIP_W-1:0]           period
);
	typedef enum {S_IDLE, S_SCAN, S_ECHO} pies_state_t;

	pies_state_t       state, next_state;           // scan sequencer
	logic [TICK_W-1:0] tickCnt, next_tickCnt;       // cycles within a ms
	logic [PIP_W-1:0]  msCnt, next_msCnt;           // ms within interval
	logic [PIP_W-1:0]  next_period;                 // active interval
	logic              periodSet, next_periodSet;   // interval configured
	logic              unicastSel, next_unicastSel; // delivery mode
	logic [CONN_W-1:0] uniTarget, next_uniTarget;   // unicast destination
	logic [NCONN-1:0]  next_ownerMask, next_listenMask;
	logic [NCONN-1:0]  mcOwnerMask, next_mcOwnerMask; // multicast owners
	logic              next_running;
	logic [CHAN_W-1:0] chanCnt, next_chanCnt;       // scan position
	logic              firstWord, next_firstWord;   // marks new data
	logic              next_reqAccept, next_reqReject;
	logic              expire;                      // interval elapsed
	logic              fifoInReady;
	logic              fifoInValid;
	pies_word_t        fifoInData;
	logic              periodOk, identOk, oneOwnerOnly;

	// range and identity checks on an incoming configuration
	assign periodOk     = (req.period >= PIP_MIN) && (req.period <= PIP_MAX);
	assign identOk      = (req.ident == deviceIdent);
	assign oneOwnerOnly = isOutput || hasOutputImage;
	assign expire = running && (tickCnt == TICK_W'(TICK_LEN - 1))
		&& (msCnt == period - 1'b1);

	// connection manager: owners, listeners, configuration
	always_comb begin
		next_ownerMask   = ownerMask;
		next_listenMask  = listenMask;
		next_mcOwnerMask = mcOwnerMask;
		next_period      = period;
		next_periodSet   = periodSet;
		next_unicastSel  = unicastSel;
		next_uniTarget   = uniTarget;
		next_reqAccept   = 1'b0;
		next_reqReject   = 1'b0;
		if (!periodSet) begin
			next_period = isOutput ? PIP_DEF_OUTPUT : PIP_DEF_INPUT;
		end
		if (reqValid) begin
			case (req.cmd)
				PIES_OPEN_OWNER: begin
					// configuration must carry identity and a legal period; with one owner only, no other slot may hold an owner
					if (!req.hasConfig || !identOk || !periodOk ||
						(oneOwnerOnly && (ownerMask & ~(NCONN'(1) << req.slot)) != '0)) begin
						next_reqReject = 1'b1;
					end else begin
						next_ownerMask[req.slot]   = 1'b1;
						next_mcOwnerMask[req.slot] = req.multicast || localChassis;
						next_period     = req.period;  // only legal value reaches here
						next_periodSet  = 1'b1;
						next_unicastSel = !req.multicast;                 // as configured
						next_uniTarget  = req.slot;
						next_reqAccept  = 1'b1;
					end
				end
				PIES_OPEN_LISTEN: begin
					// no configuration moves; needs a live owner, and a multicast owner for a multicast listener
					if (req.hasConfig || ownerMask == '0 ||
						(req.multicast && mcOwnerMask == '0)) begin
						next_reqReject = 1'b1;
					end else begin
						next_listenMask[req.slot] = 1'b1;
						next_reqAccept = 1'b1;
					end
				end
				PIES_CLOSE, PIES_LOSE: begin
					next_ownerMask[req.slot]   = 1'b0;
					next_mcOwnerMask[req.slot] = 1'b0;
					next_listenMask[req.slot]  = 1'b0;
					next_reqAccept = 1'b1;
				end
				default: begin
					next_reqReject = 1'b1;
				end
			endcase
		end
		// losing every owner drops all listeners
		if (next_ownerMask == '0) begin
			next_listenMask = '0;
		end
		// with multicast delivery (unicastSel low) a multicast listener cannot live without multicast owners; keep it simple: drop all
		if (next_mcOwnerMask == '0 && mcOwnerMask != '0 && !unicastSel) begin
			next_listenMask = '0;
		end
		next_running = (next_ownerMask != '0);
	end

	// interval timer: 1 ms tick, interval count restarts on expiry
	always_comb begin
		next_tickCnt = tickCnt;
		next_msCnt   = msCnt;
		if (!running) begin
			next_tickCnt = '0;
			next_msCnt   = '0;
		end else if (tickCnt == TICK_W'(TICK_LEN - 1)) begin
			next_tickCnt = '0;
			next_msCnt   = expire ? '0 : PIP_W'(msCnt + 1'b1);
		end else begin
			next_tickCnt = TICK_W'(tickCnt + 1'b1);
		end
	end

	// scan sequencer: walk all channels into the fifo, then idle
	always_comb begin
		next_state     = state;
		next_chanCnt   = chanCnt;
		next_firstWord = firstWord;
		fifoInValid    = 1'b0;
		case (state)
			S_IDLE: begin
				if (expire && !isOutput) begin
					next_state     = S_SCAN;
					next_chanCnt   = '0;
					next_firstWord = 1'b1;
				end else if (outDataValid && running && isOutput) begin
					next_state = S_ECHO;
				end
			end
			S_SCAN: begin
				fifoInValid = 1'b1;
				if (fifoInReady) begin
					next_firstWord = 1'b0;
					next_chanCnt   = CHAN_W'(chanCnt + 1'b1);
					if (chanCnt == CHAN_W'(NCHAN - 1)) begin
						next_state = S_IDLE;
					end
				end
			end
			S_ECHO: begin
				fifoInValid = 1'b1;
				if (fifoInReady) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		if (!running) begin
			next_state = S_IDLE;
		end
	end

	// sample port and the produced word
	assign sampleReq  = (state == S_SCAN) || (state == S_ECHO);
	assign sampleChan = (state == S_ECHO) ? outDataChan : chanCnt;
	always_comb begin
		fifoInData           = '0;
		// same chassis forces multicast on every word while the strap is set; the strap is read live, not latched
		fifoInData.multicast = !unicastSel || localChassis;
		fifoInData.target    = uniTarget;
		fifoInData.newData   = firstWord || (state == S_ECHO);
		fifoInData.echo      = (state == S_ECHO);
		fifoInData.chan      = sampleChan;
		fifoInData.value     = sampleValue;
	end

	// registers of every group
	always_ff @(posedge mclk) begin
		if (reset) begin
			state       <= S_IDLE;
			tickCnt     <= '0;
			msCnt       <= '0;
			period      <= PIP_DEF_INPUT;
			periodSet   <= 1'b0;
			unicastSel  <= 1'b0;
			uniTarget   <= '0;
			ownerMask   <= '0;
			listenMask  <= '0;
			mcOwnerMask <= '0;
			running     <= 1'b0;
			chanCnt     <= '0;
			firstWord   <= 1'b0;
			reqAccept   <= 1'b0;
			reqReject   <= 1'b0;
		end else if (clkEn) begin
			state       <= next_state;
			tickCnt     <= next_tickCnt;
			msCnt       <= next_msCnt;
			period      <= next_period;
			periodSet   <= next_periodSet;
			unicastSel  <= next_unicastSel;
			uniTarget   <= next_uniTarget;
			ownerMask   <= next_ownerMask;
			listenMask  <= next_listenMask;
			mcOwnerMask <= next_mcOwnerMask;
			running     <= next_running;
			chanCnt     <= next_chanCnt;
			firstWord   <= next_firstWord;
			reqAccept   <= next_reqAccept;
			reqReject   <= next_reqReject;
		end
	end

	// output fifo decouples the scan from backplane stalls
	pies_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.reset    (reset),
		.clkEn    (clkEn),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (prodValid),
		.outReady (prodReady),
		.outData  (prodData)
	);

	// checks
	a_period_range: assert property (@(posedge mclk) disable iff (reset)
		(period >= PIP_MIN) && (period <= PIP_MAX))
		else $error("interval out of range");
	a_default_period: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && !next_periodSet) |=> (period == (isOutput ? PIP_DEF_OUTPUT : PIP_DEF_INPUT)))
		else $error("default interval wrong");
	a_scan_after_expiry: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && expire && !isOutput && state == S_IDLE) |=> (state == S_SCAN))
		else $error("scan did not start on expiry");
	a_local_multicast: assert property (@(posedge mclk) disable iff (reset)
		(localChassis && fifoInValid) |-> fifoInData.multicast)
		else $error("local delivery not multicast");
	a_new_data_flag: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && $rose(state == S_SCAN)) |-> fifoInData.newData)
		else $error("first word not flagged new");
	a_echo_follows: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && state == S_IDLE && outDataValid && running && isOutput && !expire) |=> (state == S_ECHO))
		else $error("no echo for new output data");
	a_owner_loss: assert property (@(posedge mclk) disable iff (reset)
		(ownerMask == '0) |-> (listenMask == '0))
		else $error("listener survives owner loss");
	a_single_owner: assert property (@(posedge mclk) disable iff (reset)
		(isOutput || hasOutputImage) |-> $onehot0(ownerMask))
		else $error("second owner accepted");
	a_ident_reject: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && reqValid && req.cmd == PIES_OPEN_OWNER && req.ident != deviceIdent) |=> reqReject)
		else $error("bad identity accepted");
	a_timer_restart: assert property (@(posedge mclk) disable iff (reset)
		(clkEn && expire) |=> (msCnt == '0 || !running))
		else $error("interval count not restarted");
endmodule
`default_nettype wire

// file: inc/pies_pkg.sv
package pies_pkg;
	// timing: one interval tick per millisecond at 125 MHz
	localparam int CLK_HZ        = 125000000;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
	localparam int TICK_W        = 17;
	// packet interval period limits and defaults, in ms
	localparam logic [9:0] PIP_MIN        = 10'h001;
	localparam logic [9:0] PIP_MAX        = 10'h2EE;
	localparam logic [9:0] PIP_DEF_INPUT  = 10'h064;
	localparam logic [9:0] PIP_DEF_OUTPUT = 10'h00A;
	localparam int         PIP_W          = 10;
	// channel data
	localparam int NCHAN   = 8;
	localparam int CHAN_W  = 4;
	localparam int DATA_W  = 32;
	localparam int FIFO_DEPTH = 4;
	// connection table
	localparam int NCONN   = 4;
	localparam int CONN_W  = 2;
	// identity expected in configuration; value is arbitrary
	localparam logic [15:0] IDENT_DEFAULT = 16'h5A3C;

	// connection kinds requested by a controller
	typedef enum logic [1:0] {PIES_OPEN_OWNER, PIES_OPEN_LISTEN, PIES_CLOSE, PIES_LOSE} pies_cmd_t;

	// connection request from the backplane side
	typedef struct packed {
		pies_cmd_t           cmd;
		logic [CONN_W-1:0]   slot;
		logic                multicast;
		logic                hasConfig;
		logic [15:0]         ident;
		logic [PIP_W-1:0]    period;
	} pies_conn_req_t;

	// produced word: channel data plus framing
	typedef struct packed {
		logic                multicast;
		logic [CONN_W-1:0]   target;
		logic                newData;
		logic                echo;
		logic [CHAN_W-1:0]   chan;
		logic [DATA_W-1:0]   value;
	} pies_word_t;
	localparam int WORD_W = $bits(pies_word_t);
endpackage

// file: verif/periodic_io_exchange_scheduler_bench.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_io_exchange_scheduler_bench
	import pies_pkg::*;
;
	// clocking and straps
	logic                 mclk = 1'b0;
	logic                 reset = 1'b1;
	logic                 clkEn = 1'b1;
	logic                 isOutput = 1'b0;
	logic                 hasOutputImage = 1'b0;
	logic                 localChassis = 1'b0;
	// requests and owner data
	logic                 reqValid = 1'b0;
	pies_conn_req_t       req = '0;
	logic                 reqAccept;
	logic                 reqReject;
	logic                 outDataValid = 1'b0;
	logic [CHAN_W-1:0]    outDataChan = '0;
	// terminals, stream, status
	logic                 sampleReq;
	logic [CHAN_W-1:0]    sampleChan;
	logic [DATA_W-1:0]    sampleValue;
	logic                 prodValid;
	logic                 prodReady;
	pies_word_t           prodData;
	logic                 running;
	logic [NCONN-1:0]     ownerMask;
	logic [NCONN-1:0]     listenMask;
	logic [PIP_W-1:0]     period;
	logic                 stall = 1'b0;
	// score
	int                   miscompares = 0;
	int                   tests_run = 0;
	// a short tick keeps whole intervals inside the run; spacing math scales with it
	localparam int        BENCH_TICK = 40;

	// clock at 125 MHz
	always #4 mclk = !mclk;
	// terminal level carries its channel, so a wrong channel shows
	assign sampleValue = {28'hC0DE5A0, sampleChan};

	pies_scheduler #(
		.TICK_LEN (BENCH_TICK)
	) i_dut (.mclk(mclk), .reset(reset), .clkEn(clkEn), .isOutput(isOutput),
		.hasOutputImage(hasOutputImage), .localChassis(localChassis), .deviceIdent(IDENT_DEFAULT),
		.reqValid(reqValid), .req(req), .reqAccept(reqAccept), .reqReject(reqReject),
		.outDataValid(outDataValid), .outDataChan(outDataChan), .sampleReq(sampleReq),
		.sampleChan(sampleChan), .sampleValue(sampleValue), .prodValid(prodValid),
		.prodReady(prodReady), .prodData(prodData), .running(running), .ownerMask(ownerMask),
		.listenMask(listenMask), .period(period));
	pies_ctrl_model i_ctrl (.mclk(mclk), .stall(stall), .prodValid(prodValid),
		.prodReady(prodReady), .prodData(prodData));

	// compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask
	// verdict, reached from the main sequence or the watchdog
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// sixteen cycles of reset
	task automatic do_reset();
		@(posedge mclk);
		reset <= 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		i_ctrl.rxQ.delete(); // drop words left over from the previous scenario
	endtask
	function automatic pies_conn_req_t mk(input pies_cmd_t c, input logic [CONN_W-1:0] s,
		input logic m, input logic h, input logic [15:0] id, input logic [PIP_W-1:0] p);
		mk = '{cmd: c, slot: s, multicast: m, hasConfig: h, ident: id, period: p};
	endfunction
	// one request; answer stands in the cycle after the taking edge
	task automatic send(input pies_conn_req_t r, input logic ok);
		@(posedge mclk);
		reqValid <= 1'b1;
		req <= r;
		@(posedge mclk);
		reqValid <= 1'b0;
		#1;
		check(reqAccept, ok, "accept answer");
		check(reqReject, !ok, "reject answer");
	endtask
	// owner sends at its interval or an immediate request, any program pass
	// new output data for one channel, idle gap after
	task automatic pulse(input logic [CHAN_W-1:0] ch);
		@(posedge mclk);
		outDataValid <= 1'b1;
		outDataChan <= ch;
		@(posedge mclk);
		outDataValid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// bounded wait for the controller to hold n words
	task automatic wait_words(input int n);
		for (int k = 0; k < 200 && i_ctrl.rxQ.size() < n; k++) begin
			@(posedge mclk);
			#1;
		end
		check(i_ctrl.rxQ.size(), n, "word count");
	endtask
	// oldest word must be the echo of ch
	task automatic chk_echo(input logic [CHAN_W-1:0] ch, input logic mc);
		pies_word_t w;
		w = i_ctrl.rxQ.pop_front();
		check({w.multicast, w.newData, w.echo, w.chan, w.value},
			{mc, 2'b11, ch, 28'hC0DE5A0, ch}, "echo word");
	endtask

	// owner limits on identity, configuration and interval
	task automatic test_owner();
		check(period, PIP_DEF_INPUT, "input default");
		send(mk(PIES_OPEN_OWNER, 0, 0, 1, 16'h0000, 10), 0);
		send(mk(PIES_OPEN_OWNER, 0, 0, 0, IDENT_DEFAULT, 10), 0);
		send(mk(PIES_OPEN_OWNER, 0, 0, 1, IDENT_DEFAULT, 10'h000), 0);
		send(mk(PIES_OPEN_OWNER, 0, 0, 1, IDENT_DEFAULT, 10'h2EF), 0);
		check(running, 0, "still idle");
		send(mk(PIES_OPEN_OWNER, 0, 0, 1, IDENT_DEFAULT, 10'h2EE), 1);
		check(period, 10'h2EE, "top period");
		check(running, 1, "operating");
		send(mk(PIES_OPEN_OWNER, 1, 1, 1, IDENT_DEFAULT, 10'h001), 1);
		check(period, 10'h001, "bottom period");
		$display("done owner");
	endtask
	// listeners ride on owners
	task automatic test_listen();
		send(mk(PIES_OPEN_LISTEN, 2, 1, 1, IDENT_DEFAULT, 10), 0);
		send(mk(PIES_OPEN_LISTEN, 2, 1, 0, 16'h0000, 10'h000), 1);
		check(listenMask, 4'h4, "listener in");
		send(mk(PIES_LOSE, 1, 1, 0, 16'h0000, 10'h000), 1);
		check(listenMask, 4'h0, "multicast listener gone");
		send(mk(PIES_OPEN_LISTEN, 2, 1, 0, 16'h0000, 10'h000), 0);
		send(mk(PIES_OPEN_LISTEN, 3, 0, 0, 16'h0000, 10'h000), 1);
		send(mk(PIES_CLOSE, 0, 0, 0, 16'h0000, 10'h000), 1);
		check({running, ownerMask, listenMask}, 9'h000, "all torn down");
		send(mk(PIES_OPEN_LISTEN, 3, 0, 0, 16'h0000, 10'h000), 0);
		$display("done listen");
	endtask
	// output image allows one owner only
	task automatic test_single();
		hasOutputImage <= 1'b1;
		do_reset();
		send(mk(PIES_OPEN_OWNER, 0, 1, 1, IDENT_DEFAULT, 10), 1);
		send(mk(PIES_OPEN_OWNER, 1, 1, 1, IDENT_DEFAULT, 10), 0);
		check(ownerMask, 4'h1, "one owner");
		$display("done single");
	endtask
	// echoes fill the buffer while the controller stalls, then drain in order
	task automatic test_echo();
		logic [CHAN_W-1:0] chs[4] = '{4'h3, 4'h5, 4'h7, 4'h0};
		hasOutputImage <= 1'b0;
		isOutput <= 1'b1;
		localChassis <= 1'b1;
		do_reset();
		check(period, PIP_DEF_OUTPUT, "output default");
		send(mk(PIES_OPEN_OWNER, 0, 0, 1, IDENT_DEFAULT, 10), 1);
		stall <= 1'b1;
		foreach (chs[i]) pulse(chs[i]);
		check(prodValid, 1, "word waiting");
		check(i_ctrl.rxQ.size(), 0, "nothing taken");
		stall <= 1'b0;
		wait_words(4);
		foreach (chs[i]) chk_echo(chs[i], 1'b1);
		localChassis <= 1'b0;
		pulse(4'hF);
		wait_words(1);
		chk_echo(4'hF, 1'b0);
		send(mk(PIES_LOSE, 0, 0, 0, 16'h0000, 10'h000), 1);
		pulse(4'h2);
		repeat (20) @(posedge mclk);
		check(i_ctrl.rxQ.size(), 0, "silent after loss");
		$display("done echo");
	endtask
	// an input device scans every channel at each interval and sends them in order
	task automatic test_scan();
		pies_word_t w;
		int         gap;
		isOutput <= 1'b0;
		localChassis <= 1'b0;
		do_reset();
		// interval set once, at the opening, never while scans run
		send(mk(PIES_OPEN_OWNER, 2'h1, 1'b0, 1'b1, IDENT_DEFAULT, 10'h002), 1'b1);
		wait_words(NCHAN);
		check(sampleReq, 0, "sampling idle");
		for (int k = 0; k < NCHAN; k++) begin
			w = i_ctrl.rxQ.pop_front();
			check({w.multicast, w.target, w.newData, w.echo, w.chan, w.value},
				{1'b0, 2'h1, k == 0, 1'b0, CHAN_W'(k), 28'hC0DE5A0, CHAN_W'(k)}, "scan word");
		end
		// last word of one scan to first word of the next: one interval less the scan
		gap = 0;
		while (i_ctrl.rxQ.size() == 0 && gap < 400) begin
			@(posedge mclk);
			#1;
			gap++;
		end
		check(gap, 2 * BENCH_TICK - (NCHAN - 1), "interval spacing");
		$display("done scan");
	endtask

	// main sequence
	initial begin
		do_reset();
		test_owner();
		test_listen();
		test_single();
		test_echo();
		test_scan();
		end_of_test();
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire

// file: verif/pies_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module pies_ctrl_model
	import pies_pkg::*;
(
	// clocking
	input  wire logic       mclk,
	// bench control: hold off taking words
	input  wire logic       stall,
	// produced stream from the device
	input  wire logic       prodValid,
	output logic            prodReady,
	input  wire pies_word_t prodData
);
	// words taken so far, oldest first
	pies_word_t rxQ[$];
	// ready follows stall, which the bench only moves just after an edge
	assign prodReady = !stall;
	// take a word at the edge where valid and ready meet
	always @(posedge mclk) begin
		if (prodValid && prodReady) begin
			rxQ.push_back(prodData);
		end
	end
endmodule
`default_nettype wire
